// ===== design/jtp_pkg.sv
// Purpose: Shared constants and types for the jitter test pattern generator.
// Assumes: One 20 MHz transmit symbol clock, synchronous active-low reset.
// Notes:   The station address of the management port is arbitrary.
package jtp_pkg;
    localparam int          SYM_W      = 10;
    localparam int          FIFO_DEPTH = 8;
    localparam logic [3:0]  FIFO_SAFE  = 4'h6;   // Depth minus two: room for one in-flight push
    localparam logic [4:0]  PHY_ADDR   = 5'h00;  // Arbitrary station address
    localparam logic [4:0]  REG_ADDR   = 5'h10;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hF3FF;
    localparam int          EN_BIT     = 15;
    localparam int          SEL_HI     = 14;
    localparam int          SEL_LO     = 12;
    localparam int          CUST_HI    = 9;
    localparam int          CUST_LO    = 0;
    localparam logic [2:0]  SEL_CUSTOM = 3'h0;
    localparam logic [2:0]  SEL_HIGH   = 3'h1;
    localparam logic [2:0]  SEL_MIXED  = 3'h2;
    localparam logic [2:0]  SEL_CLOW   = 3'h3;
    localparam logic [2:0]  SEL_RAND   = 3'h4;
    localparam logic [2:0]  SEL_LOW    = 3'h5;
    localparam logic [9:0]  PAT_HIGH   = 10'h2AA;
    localparam logic [9:0]  PAT_LOW    = 10'h3E0;
    localparam logic [9:0]  PAT_MIX0   = 10'h3EB;
    localparam logic [9:0]  PAT_MIX1   = 10'h014;
    localparam logic [9:0]  LFSR_SEED  = 10'h3FF;
    localparam logic [5:0]  PRE_ONES   = 6'h20;
    localparam logic [4:0]  HDR_LAST   = 5'h0C;
    localparam logic [4:0]  TA_LAST    = 5'h01;
    localparam logic [4:0]  DATA_LAST  = 5'h0F;
    localparam logic [1:0]  OP_RD      = 2'h2;
    localparam logic [1:0]  OP_WR      = 2'h1;

    typedef enum logic [1:0] {
        MD_IDLE = 2'b00,
        MD_HDR  = 2'b01,
        MD_TA   = 2'b10,
        MD_DATA = 2'b11
    } jtp_mdio_e;

    typedef struct packed {
        logic             vld;
        logic [SYM_W-1:0] sym;
    } jtp_sym_s;
endpackage

// ===== design/jtp_fifo.sv
// Purpose: Small synchronous FIFO between the symbol source and the output stage.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Storage is flip-flops; level lets the parent derive an early ready.
`timescale 1ns/1ps
module jtp_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input  wire logic                 clk_in,       // Clock
    input  wire logic                 rst_n_in,     // Sync reset, active low
    input  wire logic                 in_valid_in,  // Write request
    output logic                      in_ready_out, // Not full
    input  wire logic [W-1:0]         in_data_in,   // Write data
    output logic                      out_valid_out,// Not empty
    input  wire logic                 out_ready_in, // Read accept
    output logic [W-1:0]              out_data_out, // Head word
    output logic [$clog2(D):0]        level_out     // Words held
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready_out  = (cnt_r != (AW+1)'(D));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rd_ptr_r];
    assign level_out     = cnt_r;
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ===== design/jtp_jitter_gen.sv
// Purpose: Transmit jitter test pattern source with its management control register.
// Assumes: MDC well below a quarter of the core clock; symbol source and transceiver share the core clock.
// Notes:   One control register sits behind the management serial frame at a single address.
// Overview of operation
// - While the enable bit is set, the selected test pattern replaces normal symbols on the transmit path.
// - Clearing the enable bit returns the path to normal encoded data and idle symbols.
// - A three-bit select field picks the pattern, and software must not use codes six and seven.
// - Select code zero sends the 10-bit custom symbol from the register.
// - Select code one sends the alternating one-zero high frequency pattern.
// - Select code two sends the 20-bit mixed frequency pattern as two alternating symbols.
// - Select code three sends five ones and five zeros, and code four sends a random pattern.
// - Select code five sends the standard five ones then five zeros low frequency pattern.
// - The custom symbol field is used when enabled with select code zero, and also with reserved codes six and seven.
`timescale 1ns/1ps
module jtp_jitter_gen (
    input  wire logic       CORE_CLK_IN,       // Transmit symbol clock, 20 MHz
    input  wire logic       RST_N_IN,          // Sync reset, active low
    input  wire logic       MDC_IN,            // Management clock pin
    input  wire logic       MDIO_IN,           // Management data pin, input
    output logic            MDIO_OUT,          // Management data pin, output
    output logic            MDIO_OE_OUT,       // Management data pin, drive enable
    input  wire logic [9:0] TX_SYM_IN,         // Normal encoded symbol
    input  wire logic       TX_SYM_VALID_IN,   // Normal symbol valid
    output logic            TX_SYM_READY_OUT,  // Normal symbol accepted
    output logic [9:0]      TBI_TXD_OUT,       // Symbol to transceiver
    output logic            TBI_TX_VALID_OUT,  // Symbol valid
    input  wire logic       TBI_TX_READY_IN    // Transceiver takes symbol
);
    logic               mdc_s1_r, mdc_s2_r, mdc_s3_r;
    logic               mdio_s1_r, mdio_s2_r;
    logic               mdc_rise;
    jtp_pkg::jtp_mdio_e md_st_r;
    logic [5:0]         ones_r;
    logic [4:0]         bit_cnt_r;
    logic [12:0]        hdr_r;
    logic [15:0]        wsh_r;
    logic [15:0]        rsh_r;
    logic               hit;
    logic               wr_now;
    logic [15:0]        ctrl_r, ctrl_nxt;
    logic               en_r;
    logic [2:0]         sel_act_r;
    logic               phase_r;
    logic               phase_nxt;
    logic [9:0]         lfsr_r;
    logic [9:0]         pat_sym;
    logic               src_ready_r;
    logic               push_vld;
    logic [9:0]         push_sym;
    logic               fifo_rdy, fifo_vld, fifo_pop;
    logic [9:0]         fifo_sym;
    logic [3:0]         fifo_lvl;
    logic               gen_fire;
    jtp_pkg::jtp_sym_s  out_r;

    // Pin synchronisers; MDC edge detect uses the second and third stages, MDIO logic uses the second
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            {mdc_s1_r, mdc_s2_r, mdc_s3_r} <= 3'h0;
            {mdio_s1_r, mdio_s2_r}         <= 2'h3;
        end else begin
            {mdc_s1_r, mdc_s2_r, mdc_s3_r} <= {MDC_IN, mdc_s1_r, mdc_s2_r};
            {mdio_s1_r, mdio_s2_r}         <= {MDIO_IN, mdio_s1_r};
        end
    end
    assign mdc_rise = mdc_s2_r & ~mdc_s3_r;

    // Frame tracker: preamble, start, opcode, addresses, turnaround, data
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            md_st_r   <= jtp_pkg::MD_IDLE;
            ones_r    <= '0;
            bit_cnt_r <= '0;
            hdr_r     <= '0;
            wsh_r     <= '0;
        end else if (mdc_rise) begin
            case (md_st_r)
                jtp_pkg::MD_IDLE: begin
                    if (mdio_s2_r) begin
                        ones_r <= (ones_r == jtp_pkg::PRE_ONES) ? ones_r : ones_r + 1'b1;
                    end else begin
                        ones_r <= '0;
                        if (ones_r == jtp_pkg::PRE_ONES) begin
                            md_st_r   <= jtp_pkg::MD_HDR;
                            bit_cnt_r <= '0;
                        end
                    end
                end
                jtp_pkg::MD_HDR: begin
                    hdr_r     <= {hdr_r[11:0], mdio_s2_r};
                    bit_cnt_r <= bit_cnt_r + 1'b1;
                    if (bit_cnt_r == jtp_pkg::HDR_LAST) begin
                        md_st_r   <= jtp_pkg::MD_TA;
                        bit_cnt_r <= '0;
                    end
                end
                jtp_pkg::MD_TA: begin
                    bit_cnt_r <= bit_cnt_r + 1'b1;
                    if (bit_cnt_r == jtp_pkg::TA_LAST) begin
                        md_st_r   <= jtp_pkg::MD_DATA;
                        bit_cnt_r <= '0;
                    end
                end
                jtp_pkg::MD_DATA: begin
                    wsh_r     <= {wsh_r[14:0], mdio_s2_r};
                    bit_cnt_r <= bit_cnt_r + 1'b1;
                    if (bit_cnt_r == jtp_pkg::DATA_LAST) begin
                        md_st_r <= jtp_pkg::MD_IDLE;
                    end
                end
                default: md_st_r <= jtp_pkg::MD_IDLE;
            endcase
        end
    end

    assign hit    = hdr_r[12] && (hdr_r[9:5] == jtp_pkg::PHY_ADDR) && (hdr_r[4:0] == jtp_pkg::REG_ADDR);
    assign wr_now = mdc_rise && (md_st_r == jtp_pkg::MD_DATA) && (bit_cnt_r == jtp_pkg::DATA_LAST)
                    && hit && (hdr_r[11:10] == jtp_pkg::OP_WR);
    // Reserved bits are masked on write so they always read zero
    assign ctrl_nxt = wr_now ? ({wsh_r[14:0], mdio_s2_r} & jtp_pkg::CTRL_WMASK) : ctrl_r;

    // Read data driven after each rising MDC so the master samples it stable on the next one
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            MDIO_OE_OUT <= 1'b0;
            MDIO_OUT    <= 1'b1;
            rsh_r       <= '0;
        end else if (mdc_rise) begin
            if (md_st_r == jtp_pkg::MD_TA && bit_cnt_r == 5'h00 && hit && hdr_r[11:10] == jtp_pkg::OP_RD) begin
                MDIO_OE_OUT <= 1'b1;
                MDIO_OUT    <= 1'b0;
                rsh_r       <= ctrl_r;
            end else if (MDIO_OE_OUT && md_st_r == jtp_pkg::MD_DATA && bit_cnt_r == jtp_pkg::DATA_LAST) begin
                MDIO_OE_OUT <= 1'b0;
                MDIO_OUT    <= 1'b1;
            end else if (MDIO_OE_OUT) begin
                MDIO_OUT <= rsh_r[15];
                rsh_r    <= {rsh_r[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            ctrl_r <= jtp_pkg::CTRL_RESET;
            en_r   <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            en_r   <= ctrl_nxt[jtp_pkg::EN_BIT];
        end
    end

    assign gen_fire = en_r & fifo_rdy;

    always_comb begin
        if (!en_r) begin
            phase_nxt = 1'b0;
        end else if (gen_fire && sel_act_r == jtp_pkg::SEL_MIXED) begin
            phase_nxt = ~phase_r;
        end else begin
            phase_nxt = phase_r;
        end
    end

    // Selection is latched only when the next symbol starts a pattern; latching on the old
    // phase could leave the second mixed half pending under another code and lock the select
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            sel_act_r <= jtp_pkg::SEL_CUSTOM;
            phase_r   <= 1'b0;
            lfsr_r    <= jtp_pkg::LFSR_SEED;
        end else begin
            if (!phase_nxt) begin
                sel_act_r <= ctrl_r[jtp_pkg::SEL_HI:jtp_pkg::SEL_LO];
            end
            phase_r <= phase_nxt;
            if (gen_fire && sel_act_r == jtp_pkg::SEL_RAND) begin
                lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
            end
        end
    end

    // Reserved codes fall back to the custom symbol rather than stalling the link
    always_comb begin
        case (sel_act_r)
            jtp_pkg::SEL_CUSTOM: pat_sym = ctrl_r[jtp_pkg::CUST_HI:jtp_pkg::CUST_LO];
            jtp_pkg::SEL_HIGH:   pat_sym = jtp_pkg::PAT_HIGH;
            jtp_pkg::SEL_MIXED:  pat_sym = phase_r ? jtp_pkg::PAT_MIX1 : jtp_pkg::PAT_MIX0;
            jtp_pkg::SEL_CLOW:   pat_sym = jtp_pkg::PAT_LOW;
            jtp_pkg::SEL_RAND:   pat_sym = lfsr_r;
            jtp_pkg::SEL_LOW:    pat_sym = jtp_pkg::PAT_LOW;
            default:             pat_sym = ctrl_r[jtp_pkg::CUST_HI:jtp_pkg::CUST_LO];
        endcase
    end

    assign push_vld = en_r ? 1'b1 : (TX_SYM_VALID_IN & src_ready_r);
    assign push_sym = en_r ? pat_sym : TX_SYM_IN;

    // Early ready leaves one free slot for the push already in flight
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            src_ready_r <= 1'b0;
        end else begin
            src_ready_r <= (fifo_lvl <= jtp_pkg::FIFO_SAFE) && !ctrl_nxt[jtp_pkg::EN_BIT];
        end
    end
    assign TX_SYM_READY_OUT = src_ready_r;

    jtp_fifo #(
        .W (jtp_pkg::SYM_W),
        .D (jtp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (CORE_CLK_IN),
        .rst_n_in      (RST_N_IN),
        .in_valid_in   (push_vld),
        .in_ready_out  (fifo_rdy),
        .in_data_in    (push_sym),
        .out_valid_out (fifo_vld),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_sym),
        .level_out     (fifo_lvl)
    );

    assign fifo_pop = fifo_vld & (~out_r.vld | TBI_TX_READY_IN);

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            out_r <= '0;
        end else if (fifo_pop) begin
            out_r <= '{vld: 1'b1, sym: fifo_sym};
        end else if (TBI_TX_READY_IN) begin
            out_r.vld <= 1'b0;
        end
    end
    assign TBI_TXD_OUT      = out_r.sym;
    assign TBI_TX_VALID_OUT = out_r.vld;

    a_test_blocks_src: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        en_r |-> !src_ready_r) else $error("normal source accepted during test mode");
    a_normal_passes: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        !en_r && TX_SYM_VALID_IN && src_ready_r |-> fifo_rdy && push_sym == TX_SYM_IN)
        else $error("normal symbol not passed");
    a_custom_symbol: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        gen_fire && sel_act_r == jtp_pkg::SEL_CUSTOM |-> push_sym == ctrl_r[9:0])
        else $error("custom symbol wrong");
    a_high_pattern: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        gen_fire && sel_act_r == jtp_pkg::SEL_HIGH |-> push_sym == 10'h2AA) else $error("high pattern wrong");
    a_mixed_pair: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        gen_fire && sel_act_r == jtp_pkg::SEL_MIXED && !phase_r && push_sym == 10'h3EB
        ##1 (fifo_rdy && en_r)[*1] |-> push_sym == 10'h014) else $error("mixed pattern second half wrong");
    a_low_patterns: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        gen_fire && (sel_act_r == jtp_pkg::SEL_CLOW || sel_act_r == jtp_pkg::SEL_LOW) |-> push_sym == 10'h3E0)
        else $error("low pattern wrong");
    a_sel_on_boundary: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        $changed(sel_act_r) |-> !phase_r) else $error("select changed mid pattern");
    a_continuous_send: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        en_r && fifo_rdy |-> push_vld ##1 (fifo_lvl != 4'h0)) else $error("test symbol not queued");
    a_reserved_zero: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
        wr_now |=> ctrl_r[11:10] == 2'h0 && ctrl_r[9:0] == $past(wsh_r[8:0] << 1 | 10'(mdio_s2_r)) )
        else $error("register write not stored");
endmodule

// ===== bench/jtp_xcvr_model.sv
// Purpose: Transceiver stand-in that accepts transmit symbols from the generator.
// Assumes: Shares the core clock; ready changes on the falling edge, away from sampling.
// Notes:   Slow mode accepts every other cycle; stall holds ready low so the FIFO backs up.
`timescale 1ns/1ps
module jtp_xcvr_model (
    input  wire logic clk_in,    // Symbol clock
    input  wire logic rst_n_in,  // Sync reset, active low
    input  wire logic slow_in,   // Accept every other cycle
    input  wire logic stall_in,  // Refuse every symbol
    output logic      ready_out  // Symbol taken at next rising edge
);
    logic phase_r;

    // Both clear while reset is low, so each has a single driver
    always @(negedge clk_in) begin
        phase_r   <= rst_n_in ? ~phase_r : 1'b0;
        ready_out <= rst_n_in && !stall_in && (!slow_in || phase_r);
    end
endmodule

// ===== bench/jtp_jitter_gen_tb.sv
// Purpose: Self-checking bench for the jitter test pattern generator.
// Assumes: MDC low for four core clocks and high for five; the bench drives inputs on the falling edge.
// Notes:   Every symbol taken by the transceiver is logged; normal traffic and the first five symbols of each pattern, bar the first random one, are compared.
`timescale 1ns/1ps
module jtp_jitter_gen_tb;
    logic        core_clk;
    logic        rst_n;
    logic        mdc;
    logic        mdio_drv;
    logic        mdio_out;
    logic        mdio_oe;
    logic        mdio_wire;
    logic [9:0]  tx_sym;
    logic        tx_vld;
    logic        tx_rdy;
    logic [9:0]  tbi_txd;
    logic        tbi_vld;
    logic        tbi_rdy;
    logic        slow;
    logic        stall;
    logic        ok;
    logic [9:0]  rx_q[$];
    logic [15:0] rd;
    logic [15:0] w;
    int          n;
    int          err_total;
    int          total_checks;

    // Released line takes the bench's own mdio_drv value
    assign mdio_wire = mdio_oe ? mdio_out : mdio_drv;

    jtp_jitter_gen dut_u (
        .CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .MDC_IN(mdc), .MDIO_IN(mdio_wire),
        .MDIO_OUT(mdio_out), .MDIO_OE_OUT(mdio_oe), .TX_SYM_IN(tx_sym), .TX_SYM_VALID_IN(tx_vld),
        .TX_SYM_READY_OUT(tx_rdy), .TBI_TXD_OUT(tbi_txd), .TBI_TX_VALID_OUT(tbi_vld),
        .TBI_TX_READY_IN(tbi_rdy)
    );

    jtp_xcvr_model xcvr_u (
        .clk_in(core_clk), .rst_n_in(rst_n), .slow_in(slow), .stall_in(stall), .ready_out(tbi_rdy)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (tbi_vld === 1'b1 && tbi_rdy === 1'b1) rx_q.push_back(tbi_txd);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One whole management frame; read data is shifted in from the last 16 bit slots
    task automatic mdio_frame(input logic [1:0] op, input logic [4:0] regad, input logic [15:0] wdata,
                              output logic [15:0] rdata);
        logic [63:0] bits;
        bits = {32'hFFFF_FFFF, 2'b01, op, jtp_pkg::PHY_ADDR, regad, 18'h3FFFF};
        if (op == jtp_pkg::OP_WR) bits[17:0] = {2'b10, wdata};
        for (int i = 63; i >= 0; i--) begin
            @(negedge core_clk);
            mdc      = 1'b0;
            mdio_drv = bits[i];
            repeat (4) @(negedge core_clk);
            if (op == jtp_pkg::OP_RD && i == 16) chk({14'h0, mdio_oe, mdio_wire}, 16'h0002);
            rdata = {rdata[14:0], mdio_wire};
            mdc   = 1'b1;
            repeat (4) @(negedge core_clk);
        end
    endtask

    // Offers one normal symbol; valid stays up so calls run back to back.
    // Ready is registered, so its settled value at the falling edge is what the next rising edge takes.
    task automatic push(input logic [9:0] s, input int lim, output logic acc);
        @(negedge core_clk);
        tx_vld = 1'b1;
        tx_sym = s;
        acc    = 1'b0;
        for (int k = 0; k < lim && !acc; k++) begin
            if (k > 0) @(negedge core_clk);
            acc = (tx_rdy === 1'b1);
            @(posedge core_clk);
        end
    endtask

    task automatic check_pat(input logic [2:0] sel);
        logic [9:0] e;
        chk({15'h0, rx_q.size() >= 5}, 16'h0001);
        for (int i = 0; i < 5 && i < rx_q.size(); i++) begin
            if (sel == jtp_pkg::SEL_RAND && i == 0) continue;
            case (sel)
                jtp_pkg::SEL_HIGH:  e = jtp_pkg::PAT_HIGH;
                jtp_pkg::SEL_MIXED: begin
                    if (i == 0) e = (rx_q[0] === jtp_pkg::PAT_MIX1) ? jtp_pkg::PAT_MIX1 : jtp_pkg::PAT_MIX0;
                    else e = (rx_q[i-1] === jtp_pkg::PAT_MIX0) ? jtp_pkg::PAT_MIX1 : jtp_pkg::PAT_MIX0;
                end
                jtp_pkg::SEL_CLOW:  e = jtp_pkg::PAT_LOW;
                jtp_pkg::SEL_RAND:  e = {rx_q[i-1][8:0], rx_q[i-1][9] ^ rx_q[i-1][6]};
                jtp_pkg::SEL_LOW:   e = jtp_pkg::PAT_LOW;
                default:            e = 10'h25A;
            endcase
            chk({6'h0, rx_q[i]}, {6'h0, e});
        end
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        $display("[ERR] %0t run did not finish in time", $time);
        summarize();
    end

    initial begin
        rst_n = 1'b0; mdc = 1'b0; mdio_drv = 1'b1; tx_sym = 10'h000; tx_vld = 1'b0;
        slow = 1'b0; stall = 1'b0; err_total = 0; total_checks = 0; n = 0;
        repeat (3) @(negedge core_clk);
        chk({13'h0, tbi_vld, mdio_oe, tx_rdy}, 16'h0000);
        rst_n = 1'b1;
        mdio_frame(jtp_pkg::OP_RD, jtp_pkg::REG_ADDR, 16'h0000, rd);
        chk(rd, jtp_pkg::CTRL_RESET);
        // Stalled transceiver: normal traffic fills the FIFO until input is refused
        stall = 1'b1;
        for (int i = 0; i < 16; i++) begin
            push(10'h100 + 10'(i), 4, ok);
            if (!ok) break;
            n++;
        end
        @(negedge core_clk);
        tx_vld = 1'b0;
        chk({15'h0, n >= 7 && n < 16}, 16'h0001);
        stall = 1'b0;
        slow  = 1'b1;
        repeat (40) @(negedge core_clk);
        chk(16'(rx_q.size()), 16'(n));
        for (int i = 0; i < n && i < rx_q.size(); i++) chk({6'h0, rx_q[i]}, 16'h0100 + 16'(i));
        // Every defined select code, with reserved bits 11:10 written as ones
        for (int s = 0; s < 6; s++) begin
            slow = s[0];
            w    = {1'b1, 3'(s), 2'b11, 10'h25A};
            mdio_frame(jtp_pkg::OP_WR, jtp_pkg::REG_ADDR, w, rd);
            mdio_frame(jtp_pkg::OP_RD, jtp_pkg::REG_ADDR, 16'h0000, rd);
            chk(rd, w & jtp_pkg::CTRL_WMASK);
            push(10'h3C3, 3, ok);
            chk({15'h0, ok}, 16'h0000);
            @(negedge core_clk);
            tx_vld = 1'b0;
            rx_q.delete();
            repeat (14) @(negedge core_clk);
            check_pat(3'(s));
        end
        // Write to another register address must leave the control register alone
        mdio_frame(jtp_pkg::OP_WR, jtp_pkg::REG_ADDR + 5'h01, 16'h0000, rd);
        mdio_frame(jtp_pkg::OP_RD, jtp_pkg::REG_ADDR, 16'h0000, rd);
        chk(rd, 16'hD25A);
        // Leaving test mode restores normal traffic
        slow = 1'b0;
        mdio_frame(jtp_pkg::OP_WR, jtp_pkg::REG_ADDR, 16'h0000, rd);
        // Test symbols already queued drain first and must not be counted as normal traffic
        repeat (20) @(negedge core_clk);
        rx_q.delete();
        for (int i = 0; i < 3; i++) push(10'h155 + 10'(i), 20, ok);
        @(negedge core_clk);
        tx_vld = 1'b0;
        repeat (10) @(negedge core_clk);
        chk(16'(rx_q.size()), 16'h0003);
        for (int i = 0; i < 3 && i < rx_q.size(); i++) chk({6'h0, rx_q[i]}, 16'h0155 + 16'(i));
        summarize();
    end
endmodule
